// ---- core/kspc_pkg.sv ----
/*
 * Package for the key slot permission checker: register map, policy word
 * field positions, write permission bit positions, command codes, verdicts.
 * Assumes a 32-bit Avalon-MM register bus with word-aligned registers.
 */
package kspc_pkg;
	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int NUM_SLOTS   = 16;
	localparam int SLOT_W      = 4;
	localparam int ADDR_W      = 8;

	// ************************************************************
	// Register byte addresses
	// ************************************************************
	localparam logic [ADDR_W-1:0] CERT_FMT_OFS  = 8'h5C; // Bytes 92-95
	localparam logic [ADDR_W-1:0] POLICY_OFS    = 8'h60; // Bytes 96..127
	localparam logic [ADDR_W-1:0] SETUP_OFS     = 8'h80; // Setup words
	localparam logic [ADDR_W-1:0] CTRL_OFS      = 8'hC0;
	localparam logic [ADDR_W-1:0] FROZEN_OFS    = 8'hC4;
	localparam logic [ADDR_W-1:0] AUTHDONE_OFS  = 8'hC8;
	localparam logic [ADDR_W-1:0] STATUS_OFS    = 8'hCC;

	// ************************************************************
	// Control register fields
	// ************************************************************
	localparam int CTRL_DATA_LOCK = 0;
	localparam int CTRL_TAMPER    = 1;

	// ************************************************************
	// Policy word fields
	// ************************************************************
	localparam int POL_CERT_HI   = 15;
	localparam int POL_CERT_LO   = 14;
	localparam int POL_TAMPER    = 12;
	localparam int POL_AUTH_HI   = 11;
	localparam int POL_AUTH_LO   = 8;
	localparam int POL_REQ_AUTH  = 7;
	localparam int POL_REQ_NONCE = 6;
	localparam int POL_LOCKABLE  = 5;
	localparam int POL_KIND_HI   = 4;
	localparam int POL_KIND_LO   = 2;
	localparam int POL_PRIVATE   = 0;
	localparam logic [2:0] KIND_P256  = 3'h4;
	localparam logic [2:0] KIND_OTHER = 3'h7;

	// ************************************************************
	// Setup word fields
	// ************************************************************
	localparam int WP_HI        = 15;
	localparam int WP_LO        = 12;
	localparam int WP_GEN_OK    = 13;
	localparam int WP_ENC_OK    = 14;
	localparam int WKEY_HI      = 11;
	localparam int WKEY_LO      = 8;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [15:0] POLICY_RST = 16'h001C;
	localparam logic [15:0] SETUP_RST  = 16'h0000;
	localparam logic [7:0]  CERT_RST   = 8'h00;

	// ************************************************************
	// Commands and verdicts
	// ************************************************************
	typedef enum logic [3:0] {
		CMD_WRITE   = 4'h0,
		CMD_DERIVE  = 4'h1,
		CMD_RANDOM_KEY_GENERATION_CMD  = 4'h2,
		CMD_PRIVWR  = 4'h3,
		CMD_SIGN    = 4'h4,
		CMD_SHARED  = 4'h5,
		CMD_MAC     = 4'h6,
		CMD_HMAC    = 4'h7,
		CMD_CHKDIG  = 4'h8,
		CMD_VERIFY  = 4'h9,
		CMD_DIGEST_GENERATION_CMD  = 4'hA,
		CMD_LOCK    = 4'hB,
		CMD_READ    = 4'hC
	} kspc_cmd_t;

	typedef enum logic [3:0] {
		ERR_NONE     = 4'h0,
		ERR_PRIV_WR  = 4'h1,
		ERR_NOT_PRIV = 4'h2,
		ERR_GEN_PERM = 4'h3,
		ERR_ENC_PERM = 4'h4,
		ERR_MAC_BAD  = 4'h5,
		ERR_TAMPER   = 4'h6,
		ERR_AUTH     = 4'h7,
		ERR_NONCE    = 4'h8,
		ERR_LOCKABLE = 4'h9,
		ERR_FROZEN   = 4'hA,
		ERR_PRIV_USE = 4'hB
	} kspc_err_t;
endpackage

// ---- core/kspc_rule_eval.sv ----
/*
 * Combinational verdict for one command against one slot's policy.
 * Assumes the caller holds the policy and setup words stable while read.
 */
`timescale 1ns/100ps
module kspc_rule_eval
	import kspc_pkg::*;
(
	input  wire kspc_pkg::kspc_cmd_t cmd,
	input  wire logic [15:0]         policyWord,
	input  wire logic [15:0]         setupWord,
	input  wire logic                dataLocked,
	input  wire logic                tamperState,
	input  wire logic                authDone,
	input  wire logic                nonceOk,
	input  wire logic                macOk,
	input  wire logic                slotFrozen,
	output kspc_pkg::kspc_err_t      verdict
);
	logic       isPriv;
	logic [3:0] wp;

	// Slot is a private key when flagged private and curve kind says P256
	assign isPriv = policyWord[POL_PRIVATE] &&
		(policyWord[POL_KIND_HI:POL_KIND_LO] == KIND_P256);
	assign wp = setupWord[WP_HI:WP_LO];

	// Checks in priority order; first failure wins
	always_comb begin
		verdict = ERR_NONE;
		if ((cmd == CMD_WRITE || cmd == CMD_DERIVE) && isPriv) begin
			verdict = ERR_PRIV_WR;
		end else if ((cmd == CMD_RANDOM_KEY_GENERATION_CMD || cmd == CMD_PRIVWR) && !isPriv) begin
			verdict = ERR_NOT_PRIV;
		end else if (cmd == CMD_PRIVWR && !wp[WP_ENC_OK-WP_LO]) begin
			verdict = ERR_ENC_PERM;
		end else if (cmd == CMD_PRIVWR && !macOk) begin
			verdict = ERR_MAC_BAD;
		end else if (cmd == CMD_RANDOM_KEY_GENERATION_CMD && !wp[WP_GEN_OK-WP_LO]) begin
			// Setup word gate, so it holds before the lock too
			verdict = ERR_GEN_PERM;
		end else if (!dataLocked) begin
			// Policy restrictions wait for data zone lock
			verdict = ERR_NONE;
		end else if (cmd == CMD_SIGN || cmd == CMD_SHARED) begin
			if (!isPriv)
				verdict = ERR_NOT_PRIV;
		end else if (policyWord[POL_PRIVATE] && cmd != CMD_RANDOM_KEY_GENERATION_CMD &&
				cmd != CMD_PRIVWR) begin
			verdict = ERR_PRIV_USE;
		end
		// Usage gates applied after command-specific checks
		if (verdict == ERR_NONE && dataLocked) begin
			if (policyWord[POL_TAMPER] && !tamperState &&
					cmd != CMD_RANDOM_KEY_GENERATION_CMD)
				verdict = ERR_TAMPER;
			else if (policyWord[POL_REQ_AUTH] && !authDone &&
					cmd != CMD_WRITE && cmd != CMD_LOCK &&
					cmd != CMD_READ)
				verdict = ERR_AUTH;
			else if (policyWord[POL_REQ_NONCE] && !nonceOk &&
					(cmd == CMD_RANDOM_KEY_GENERATION_CMD || cmd == CMD_MAC ||
					cmd == CMD_HMAC || cmd == CMD_CHKDIG ||
					cmd == CMD_VERIFY || cmd == CMD_DERIVE ||
					cmd == CMD_DIGEST_GENERATION_CMD))
				verdict = ERR_NONCE;
			else if (cmd == CMD_LOCK && !policyWord[POL_LOCKABLE])
				verdict = ERR_LOCKABLE;
			else if (slotFrozen && (cmd == CMD_WRITE ||
					cmd == CMD_DERIVE || cmd == CMD_RANDOM_KEY_GENERATION_CMD ||
					cmd == CMD_PRIVWR || cmd == CMD_LOCK))
				verdict = ERR_FROZEN;
		end
	end
endmodule // kspc_rule_eval

// ---- core/kspc_top.sv ----
/*
 * Key slot permission checker: per-slot policy words, setup words and
 * certificate format bytes behind an Avalon-MM slave, plus a one-cycle
 * command check port that grants or refuses a command on a slot.
 * Assumes command inputs are synchronous to clk and a request is held
 * only for the cycle cmdValid is high.
 */
// The Avalon-MM register port was decided locally.
`timescale 1ns/100ps

// Overview of operation
// - Private slots never written by write/derive
// - Generate or private-write need private slot
// - Generation needs write permission bit 13
// - Private write needs write permission bit 14
// - Private write accepted only with good MAC
// - Policy beyond the private-key checks enforced only after data lock
// - Unlocked: private slots written only encrypted
// - Sixteen two-byte policy words from byte 96
// - Policy bits 15-14 pick certificate format byte
// - Tamper gate blocks all but generation
// - Bits 11-8 select authorising slot
// - Bit 7 demands prior authorisation first
// - Bit 6 demands random nonce for listed commands
// - Bit 5 allows individual slot lock
// - Bits 4-2 give curve kind
// - Bit 0 restricts slot to private commands
// - Write permission field is setup bits 15-12
module kspc_top
	import kspc_pkg::*;
#(
	parameter int NSLOT = NUM_SLOTS
)(
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	// Avalon-MM slave
	input  wire logic [kspc_pkg::ADDR_W-1:0] avsAddress,
	input  wire logic                       avsRead,
	input  wire logic                       avsWrite,
	input  wire logic [31:0]                avsWriteData,
	input  wire logic [3:0]                 avsByteEnable,
	output logic [31:0]                     avsReadData,
	output logic                            avsWaitRequest,
	output logic [1:0]                      avsResponse,
	// Command check port
	input  wire logic                       cmdValid,
	input  wire kspc_pkg::kspc_cmd_t        cmdCode,
	input  wire logic [kspc_pkg::SLOT_W-1:0] cmdSlot,
	input  wire logic                       cmdNonceOk,
	input  wire logic                       cmdMacOk,
	input  wire logic                       cmdAuthOk,
	output logic                            rspValid,
	output logic                            rspGrant,
	output kspc_pkg::kspc_err_t             rspErr,
	output logic [7:0]                      rspCertFmt,
	output logic [kspc_pkg::SLOT_W-1:0]     rspAuthSlot,
	output logic [kspc_pkg::SLOT_W-1:0]     rspWriteKeySlot
);
	// ************************************************************
	// State
	// ************************************************************
	logic [15:0] policy_ff  [NSLOT];
	logic [15:0] nxt_policy [NSLOT];
	logic [15:0] setup_ff   [NSLOT];
	logic [15:0] nxt_setup  [NSLOT];
	logic [7:0]  cert_ff    [4];
	logic [7:0]  nxt_cert   [4];
	logic [NSLOT-1:0] frozen_ff, nxt_frozen;
	logic [NSLOT-1:0] authDone_ff, nxt_authDone;
	logic        dataLock_ff, nxt_dataLock;
	logic        tamper_ff, nxt_tamper;
	logic [31:0] rdData_ff, nxt_rdData;
	logic        ack_ff, nxt_ack;
	logic [1:0]  resp_ff, nxt_resp;
	logic        rspValid_ff, nxt_rspValid;
	logic        rspGrant_ff, nxt_rspGrant;
	kspc_err_t   rspErr_ff, nxt_rspErr;
	kspc_err_t   lastErr_ff, nxt_lastErr;
	logic [7:0]  rspCert_ff, nxt_rspCert;
	logic [SLOT_W-1:0] rspAuth_ff, nxt_rspAuth;
	logic [SLOT_W-1:0] rspWkey_ff, nxt_rspWkey;

	// ************************************************************
	// Command evaluation
	// ************************************************************
	kspc_err_t   verdict;
	logic [15:0] selPolicy;
	logic [15:0] selSetup;
	logic        reqBus;
	logic        wrEn;

	assign selPolicy = policy_ff[cmdSlot];
	assign selSetup  = setup_ff[cmdSlot];

	kspc_rule_eval u_eval (
		.cmd         (cmdCode),
		.policyWord  (selPolicy),
		.setupWord   (selSetup),
		.dataLocked  (dataLock_ff),
		.tamperState (tamper_ff),
		.authDone    (authDone_ff[selPolicy[POL_AUTH_HI:POL_AUTH_LO]]),
		.nonceOk     (cmdNonceOk),
		.macOk       (cmdMacOk),
		.slotFrozen  (frozen_ff[cmdSlot]),
		.verdict     (verdict)
	);

	// ************************************************************
	// Bus access decode
	// ************************************************************
	// One wait cycle per access, answer on the second edge
	assign reqBus         = (avsRead || avsWrite) && !ack_ff;
	assign avsWaitRequest = (avsRead || avsWrite) && !ack_ff;
	// Writes land only at the edge where waitrequest is low
	assign wrEn           = avsWrite && ack_ff;
	assign avsReadData    = rdData_ff;
	assign avsResponse    = resp_ff;

	// Next state for registers, bus answer and command response
	always_comb begin
		logic [ADDR_W-1:0] a;
		logic [31:0]       rd;
		logic              hit;
		int                idx;
		a   = avsAddress;
		rd  = 32'h0000_0000;
		hit = 1'b0;
		idx = 0;
		for (int i = 0; i < NSLOT; i++) begin
			nxt_policy[i] = policy_ff[i];
			nxt_setup[i]  = setup_ff[i];
		end
		for (int i = 0; i < 4; i++)
			nxt_cert[i] = cert_ff[i];
		nxt_frozen   = frozen_ff;
		nxt_authDone = authDone_ff;
		nxt_dataLock = dataLock_ff;
		nxt_tamper   = tamper_ff;
		nxt_rdData   = rdData_ff;
		nxt_ack      = reqBus;
		nxt_resp     = resp_ff;
		nxt_lastErr  = lastErr_ff;
		nxt_rspValid = cmdValid;
		nxt_rspGrant = rspGrant_ff;
		nxt_rspErr   = rspErr_ff;
		nxt_rspCert  = rspCert_ff;
		nxt_rspAuth  = rspAuth_ff;
		nxt_rspWkey  = rspWkey_ff;

		// Register access; data zone lock freezes the policy map
		if (avsRead || avsWrite) begin
			if (a >= POLICY_OFS && a < POLICY_OFS + 8'(4 * NSLOT / 2)
					&& a < SETUP_OFS) begin
				idx = int'((a - POLICY_OFS) >> 1);
				hit = 1'b1;
				rd  = {policy_ff[idx + 1], policy_ff[idx]};
				if (wrEn && !dataLock_ff) begin
					if (avsByteEnable[0])
						nxt_policy[idx][7:0] = avsWriteData[7:0];
					if (avsByteEnable[1])
						nxt_policy[idx][15:8] = avsWriteData[15:8];
					if (avsByteEnable[2])
						nxt_policy[idx + 1][7:0] = avsWriteData[23:16];
					if (avsByteEnable[3])
						nxt_policy[idx + 1][15:8] = avsWriteData[31:24];
				end
			end else if (a >= SETUP_OFS &&
					a < SETUP_OFS + 8'(2 * NSLOT)) begin
				idx = int'((a - SETUP_OFS) >> 1);
				hit = 1'b1;
				rd  = {setup_ff[idx + 1], setup_ff[idx]};
				if (wrEn && !dataLock_ff) begin
					if (avsByteEnable[0])
						nxt_setup[idx][7:0] = avsWriteData[7:0];
					if (avsByteEnable[1])
						nxt_setup[idx][15:8] = avsWriteData[15:8];
					if (avsByteEnable[2])
						nxt_setup[idx + 1][7:0] = avsWriteData[23:16];
					if (avsByteEnable[3])
						nxt_setup[idx + 1][15:8] = avsWriteData[31:24];
				end
			end else if (a == CERT_FMT_OFS) begin
				hit = 1'b1;
				rd  = {cert_ff[3], cert_ff[2], cert_ff[1], cert_ff[0]};
				for (int b = 0; b < 4; b++)
					if (wrEn && !dataLock_ff && avsByteEnable[b])
						nxt_cert[b] = avsWriteData[8*b +: 8];
			end else if (a == CTRL_OFS) begin
				hit = 1'b1;
				rd  = {30'h0000_0000, tamper_ff, dataLock_ff};
				if (wrEn && avsByteEnable[0]) begin
					// Lock is one-way: only set, never cleared
					nxt_dataLock = dataLock_ff |
						avsWriteData[CTRL_DATA_LOCK];
					nxt_tamper = avsWriteData[CTRL_TAMPER];
				end
			end else if (a == FROZEN_OFS) begin
				hit = 1'b1;
				rd  = 32'(frozen_ff);
			end else if (a == AUTHDONE_OFS) begin
				hit = 1'b1;
				rd  = 32'(authDone_ff);
				if (wrEn)
					nxt_authDone = NSLOT'(avsWriteData);
			end else if (a == STATUS_OFS) begin
				hit = 1'b1;
				rd  = {28'h000_0000, lastErr_ff};
			end
			// Answer loaded in the wait cycle, stands at the ack edge
			if (reqBus) begin
				nxt_rdData = avsRead ? rd : 32'h0000_0000;
				nxt_resp   = hit ? 2'h0 : 2'h2;
			end
		end

		// Command check; only a granted command may alter slot state
		if (cmdValid) begin
			nxt_rspGrant = (verdict == ERR_NONE);
			nxt_rspErr   = verdict;
			nxt_lastErr  = verdict;
			nxt_rspCert  = cert_ff[selPolicy[POL_CERT_HI:POL_CERT_LO]];
			nxt_rspAuth  = selPolicy[POL_AUTH_HI:POL_AUTH_LO];
			nxt_rspWkey  = selSetup[WKEY_HI:WKEY_LO];
			if (verdict == ERR_NONE && cmdCode == CMD_LOCK)
				nxt_frozen[cmdSlot] = 1'b1;
			if (verdict == ERR_NONE && cmdAuthOk)
				nxt_authDone[cmdSlot] = 1'b1;
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NSLOT; i++) begin
				policy_ff[i] <= POLICY_RST;
				setup_ff[i]  <= SETUP_RST;
			end
			for (int i = 0; i < 4; i++)
				cert_ff[i] <= CERT_RST;
			frozen_ff   <= '0;
			authDone_ff <= '0;
			dataLock_ff <= 1'b0;
			tamper_ff   <= 1'b0;
			rdData_ff   <= 32'h0000_0000;
			ack_ff      <= 1'b0;
			resp_ff     <= 2'h0;
			rspValid_ff <= 1'b0;
			rspGrant_ff <= 1'b0;
			rspErr_ff   <= ERR_NONE;
			lastErr_ff  <= ERR_NONE;
			rspCert_ff  <= 8'h00;
			rspAuth_ff  <= '0;
			rspWkey_ff  <= '0;
		end else begin
			policy_ff   <= nxt_policy;
			setup_ff    <= nxt_setup;
			cert_ff     <= nxt_cert;
			frozen_ff   <= nxt_frozen;
			authDone_ff <= nxt_authDone;
			dataLock_ff <= nxt_dataLock;
			tamper_ff   <= nxt_tamper;
			rdData_ff   <= nxt_rdData;
			ack_ff      <= nxt_ack;
			resp_ff     <= nxt_resp;
			rspValid_ff <= nxt_rspValid;
			rspGrant_ff <= nxt_rspGrant;
			rspErr_ff   <= nxt_rspErr;
			lastErr_ff  <= nxt_lastErr;
			rspCert_ff  <= nxt_rspCert;
			rspAuth_ff  <= nxt_rspAuth;
			rspWkey_ff  <= nxt_rspWkey;
		end
	end

	// Response outputs straight from flops
	assign rspValid        = rspValid_ff;
	assign rspGrant        = rspGrant_ff;
	assign rspErr          = rspErr_ff;
	assign rspCertFmt      = rspCert_ff;
	assign rspAuthSlot     = rspAuth_ff;
	assign rspWriteKeySlot = rspWkey_ff;
endmodule // kspc_top

// ---- sim/kspc_host_model.sv ----
/* Host model: Avalon-MM master for the checker's register bus.
   Assumes a free-running clk and one task call at a time. */
`timescale 1ns/100ps
module kspc_host_model
	import kspc_pkg::*;
(
	input  wire logic                   clk,
	output logic [kspc_pkg::ADDR_W-1:0] avsAddress,
	output logic                        avsRead,
	output logic                        avsWrite,
	output logic [31:0]                 avsWriteData,
	output logic [3:0]                  avsByteEnable,
	input  wire logic [31:0]            avsReadData,
	input  wire logic                   avsWaitRequest,
	input  wire logic [1:0]             avsResponse
);
	// Bus idle from time zero, all lanes always enabled
	initial begin
		avsAddress = '0;
		avsRead = 1'b0;
		avsWrite = 1'b0;
		avsWriteData = '0;
		avsByteEnable = 4'hF;
	end

	// ************************************************************
	// One access; request held until waitrequest is sampled low
	// ************************************************************
	task automatic busAccess(input logic wr, input logic [7:0] adr,
		input logic [31:0] dat, output logic [31:0] rd,
		output logic [1:0] rsp);
		@(posedge clk);
		avsAddress <= adr;
		avsWriteData <= dat;
		avsRead <= !wr;
		avsWrite <= wr;
		// No cycle count assumed; the bench timeout cuts a hang
		do @(posedge clk); while (avsWaitRequest !== 1'b0);
		rd = avsReadData;
		rsp = avsResponse;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
	endtask
endmodule // kspc_host_model

// ---- sim/kspc_top_assertions.sv ----
/* Checker for the permission checker's ports: bus timing, response
   timing and verdict causes. Assumes binding onto kspc_top. */
`timescale 1ns/100ps
module kspc_top_chk
	import kspc_pkg::*;
#(
	parameter int NSLOT = NUM_SLOTS
)(
	input wire logic                        clk,
	input wire logic                        rst_b,
	input wire logic [kspc_pkg::ADDR_W-1:0] avsAddress,
	input wire logic                        avsRead,
	input wire logic                        avsWrite,
	input wire logic                        avsWaitRequest,
	input wire logic [1:0]                  avsResponse,
	input wire logic                        cmdValid,
	input wire kspc_pkg::kspc_cmd_t         cmdCode,
	input wire logic                        cmdNonceOk,
	input wire logic                        cmdMacOk,
	input wire logic                        rspValid,
	input wire logic                        rspGrant,
	input wire kspc_pkg::kspc_err_t         rspErr
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// ************************************************************
	// Bus handshake
	// ************************************************************
	sequence reqStart;
		$rose(avsRead) || $rose(avsWrite);
	endsequence
	sequence oneWait;
		avsWaitRequest ##1 !avsWaitRequest;
	endsequence
	// Holes checked here sit between setup words and control, and above status; bytes below 92 are holes too
	logic holeAdr;
	assign holeAdr = (avsAddress >= 8'hD0) ||
		(avsAddress >= 8'hA0 && avsAddress < 8'hC0);

	chk_bus_wait: assert property (reqStart |-> oneWait)
		else $error("bus wait state count wrong");
	chk_bus_idle: assert property (!(avsRead || avsWrite) |-> !avsWaitRequest)
		else $error("waitrequest without request");
	chk_bus_hole: assert property ((avsRead || avsWrite) && !avsWaitRequest
		&& holeAdr |-> avsResponse == 2'b10)
		else $error("unmapped access not refused");

	// ************************************************************
	// Command verdicts
	// ************************************************************
	chk_rsp_lat: assert property (cmdValid |=> rspValid)
		else $error("response missing");
	chk_rsp_pulse: assert property (!cmdValid |=> !rspValid)
		else $error("response without command");
	chk_rsp_hold: assert property (!rspValid |-> $stable(rspErr))
		else $error("verdict changed between commands");
	chk_grant_err: assert property (rspValid |-> rspGrant == (rspErr == ERR_NONE))
		else $error("grant and error disagree");
	chk_priv_wr: assert property (rspValid && rspErr == ERR_PRIV_WR |->
		$past(cmdCode) inside {CMD_WRITE, CMD_DERIVE})
		else $error("private write error on wrong command");
	chk_not_priv: assert property (rspValid && rspErr == ERR_NOT_PRIV |->
		$past(cmdCode) inside {CMD_RANDOM_KEY_GENERATION_CMD, CMD_PRIVWR, CMD_SIGN,
		CMD_SHARED})
		else $error("not-private error on wrong command");
	chk_gen_perm: assert property (rspValid && rspErr == ERR_GEN_PERM |->
		$past(cmdCode) == CMD_RANDOM_KEY_GENERATION_CMD)
		else $error("generation error on wrong command");
	chk_enc_perm: assert property (rspValid && rspErr == ERR_ENC_PERM |->
		$past(cmdCode) == CMD_PRIVWR)
		else $error("encrypted write error on wrong command");
	chk_mac_bad: assert property (rspValid && rspErr == ERR_MAC_BAD |->
		$past(cmdCode) == CMD_PRIVWR && !$past(cmdMacOk))
		else $error("mac error without bad mac");
	chk_tamper_gen: assert property (rspValid && rspErr == ERR_TAMPER |->
		$past(cmdCode) != CMD_RANDOM_KEY_GENERATION_CMD)
		else $error("generation refused by tamper gate");
	chk_nonce_req: assert property (rspValid && rspErr == ERR_NONCE |->
		!$past(cmdNonceOk))
		else $error("nonce error with nonce present");
endmodule // kspc_top_chk

bind kspc_top kspc_top_chk #(.NSLOT(NSLOT)) uChk (.clk(clk), .rst_b(rst_b),
	.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
	.avsWaitRequest(avsWaitRequest), .avsResponse(avsResponse),
	.cmdValid(cmdValid), .cmdCode(cmdCode), .cmdNonceOk(cmdNonceOk),
	.cmdMacOk(cmdMacOk), .rspValid(rspValid), .rspGrant(rspGrant),
	.rspErr(rspErr));

// ---- sim/testbench.sv ----
/* Self-checking bench for kspc_top: row table of configuration writes
   and commands, then hand tests. Assumes the host model and checker. */
`timescale 1ns/100ps
module testbench;
	import kspc_pkg::*;
	typedef struct {
		logic bus; logic [7:0] adr; logic [31:0] dat;
		kspc_cmd_t cmd; logic [3:0] slot; logic [2:0] q; kspc_err_t err;
	} kspc_row_t;
	logic clk, rst_b, cmdValid, cmdNonceOk, cmdMacOk, cmdAuthOk;
	logic avsRead, avsWrite, avsWaitRequest, rspValid, rspGrant;
	logic [7:0] avsAddress, rspCertFmt;
	logic [31:0] avsWriteData, avsReadData, rd;
	logic [3:0] avsByteEnable, cmdSlot, rspAuthSlot, rspWriteKeySlot;
	logic [1:0] avsResponse, rsp;
	kspc_cmd_t cmdCode;
	kspc_err_t rspErr;
	kspc_row_t rows[$];
	kspc_cmd_t nonceCmds[5] = '{CMD_MAC, CMD_HMAC, CMD_CHKDIG,
		CMD_VERIFY, CMD_DIGEST_GENERATION_CMD};
	int errCount = 0, compares = 0, cycles = 0;

	kspc_top dut (.clk(clk), .rst_b(rst_b), .avsAddress(avsAddress),
		.avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
		.avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
		.avsWaitRequest(avsWaitRequest), .avsResponse(avsResponse),
		.cmdValid(cmdValid), .cmdCode(cmdCode), .cmdSlot(cmdSlot),
		.cmdNonceOk(cmdNonceOk), .cmdMacOk(cmdMacOk), .cmdAuthOk(cmdAuthOk),
		.rspValid(rspValid), .rspGrant(rspGrant), .rspErr(rspErr),
		.rspCertFmt(rspCertFmt), .rspAuthSlot(rspAuthSlot),
		.rspWriteKeySlot(rspWriteKeySlot));
	kspc_host_model host (.clk(clk), .avsAddress(avsAddress),
		.avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
		.avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
		.avsWaitRequest(avsWaitRequest), .avsResponse(avsResponse));

	// ************************************************************
	// Clock, timeout, helpers
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Whole run is well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			errCount++;
			summarize();
		end
	end
	task automatic check(input logic [31:0] seen, exp, input string msg);
		compares++;
		if (seen !== exp) begin
			errCount++;
			$display("mismatch t=%0t %s", $time, msg);
		end
	endtask
	function automatic kspc_row_t bw(input logic [7:0] a,
		input logic [31:0] d);
		bw = '{1'b1, a, d, CMD_READ, 4'h0, 3'h0, ERR_NONE};
	endfunction
	// q packs nonce, mac and auth qualifiers
	function automatic kspc_row_t cr(input kspc_cmd_t c,
		input logic [3:0] s, input logic [2:0] q, input kspc_err_t e);
		cr = '{1'b0, 8'h00, 32'h0, c, s, q, e};
	endfunction
	// One pulse, verdict looked at in the response cycle
	task automatic doCmd(input kspc_row_t r);
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdCode <= r.cmd;
		cmdSlot <= r.slot;
		{cmdNonceOk, cmdMacOk, cmdAuthOk} <= r.q;
		@(posedge clk);
		cmdValid <= 1'b0;
		@(negedge clk);
		check(rspValid, 1, "no response");
		check(rspErr, r.err, "verdict");
		check(rspGrant, r.err == ERR_NONE, "grant");
	endtask
	task automatic summarize();
		$display("compares=%0d mismatches=%0d", compares, errCount);
		if (errCount == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		rst_b = 1'b0;
		cmdValid = 1'b0;
		cmdCode = CMD_READ;
		cmdSlot = 4'h0;
		{cmdNonceOk, cmdMacOk, cmdAuthOk} = 3'h0;
		// Slot0 private, slot3 gated by tamper, auth, nonce, lockable
		rows.push_back(bw(POLICY_OFS, 32'h001C0011));
		rows.push_back(bw(8'h64, 32'h95FC0011));
		rows.push_back(bw(SETUP_OFS, 32'h00006700));
		rows.push_back(bw(CERT_FMT_OFS, 32'h44332211));
		rows.push_back(cr(CMD_WRITE, 4'h0, 3'h0, ERR_PRIV_WR));
		rows.push_back(cr(CMD_DERIVE, 4'h0, 3'h0, ERR_PRIV_WR));
		rows.push_back(cr(CMD_RANDOM_KEY_GENERATION_CMD, 4'h1, 3'h0, ERR_NOT_PRIV));
		rows.push_back(cr(CMD_PRIVWR, 4'h1, 3'h2, ERR_NOT_PRIV));
		rows.push_back(cr(CMD_PRIVWR, 4'h2, 3'h2, ERR_ENC_PERM));
		rows.push_back(cr(CMD_PRIVWR, 4'h0, 3'h0, ERR_MAC_BAD));
		rows.push_back(cr(CMD_PRIVWR, 4'h0, 3'h2, ERR_NONE));
		rows.push_back(cr(CMD_RANDOM_KEY_GENERATION_CMD, 4'h2, 3'h0, ERR_GEN_PERM));
		rows.push_back(cr(CMD_MAC, 4'h3, 3'h0, ERR_NONE));
		rows.push_back(cr(CMD_WRITE, 4'h1, 3'h0, ERR_NONE));
		rows.push_back(bw(CTRL_OFS, 32'h1));
		rows.push_back(cr(CMD_RANDOM_KEY_GENERATION_CMD, 4'h2, 3'h0, ERR_GEN_PERM));
		rows.push_back(cr(CMD_RANDOM_KEY_GENERATION_CMD, 4'h0, 3'h0, ERR_NONE));
		rows.push_back(cr(CMD_SIGN, 4'h1, 3'h0, ERR_NOT_PRIV));
		rows.push_back(cr(CMD_SHARED, 4'h1, 3'h0, ERR_NOT_PRIV));
		rows.push_back(cr(CMD_MAC, 4'h0, 3'h0, ERR_PRIV_USE));
		rows.push_back(cr(CMD_MAC, 4'h3, 3'h4, ERR_TAMPER));
		rows.push_back(cr(CMD_MAC, 4'h1, 3'h0, ERR_NONE));
		rows.push_back(bw(CTRL_OFS, 32'h3));
		rows.push_back(cr(CMD_MAC, 4'h3, 3'h4, ERR_AUTH));
		rows.push_back(cr(CMD_MAC, 4'h5, 3'h1, ERR_NONE));
		rows.push_back(cr(CMD_MAC, 4'h3, 3'h4, ERR_NONE));
		foreach (nonceCmds[i])
			rows.push_back(cr(nonceCmds[i], 4'h3, 3'h0, ERR_NONCE));
		rows.push_back(cr(CMD_LOCK, 4'h1, 3'h0, ERR_LOCKABLE));
		rows.push_back(cr(CMD_LOCK, 4'h3, 3'h0, ERR_NONE));
		rows.push_back(cr(CMD_LOCK, 4'h3, 3'h0, ERR_FROZEN));
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].bus) begin
				host.busAccess(1'b1, rows[i].adr, rows[i].dat, rd, rsp);
				check(rsp, 2'b00, "config write refused");
			end else doCmd(rows[i]);
		end
		$display("test table done");
		// Pointers and certificate format reported with the verdict
		doCmd(cr(CMD_MAC, 4'h3, 3'h4, ERR_NONE));
		check(rspCertFmt, 8'h33, "cert format");
		check(rspAuthSlot, 4'h5, "auth slot");
		doCmd(cr(CMD_RANDOM_KEY_GENERATION_CMD, 4'h0, 3'h0, ERR_NONE));
		check(rspWriteKeySlot, 4'h7, "write key slot");
		$display("test pointers done");
		// Locked policy and read-only frozen flags ignore writes
		host.busAccess(1'b1, POLICY_OFS, 32'hFFFFFFFF, rd, rsp);
		host.busAccess(1'b0, POLICY_OFS, 32'h0, rd, rsp);
		check(rd, 32'h001C0011, "policy changed after lock");
		host.busAccess(1'b1, FROZEN_OFS, 32'h0, rd, rsp);
		host.busAccess(1'b0, FROZEN_OFS, 32'h0, rd, rsp);
		check(rd, 32'h8, "frozen flags");
		host.busAccess(1'b0, AUTHDONE_OFS, 32'h0, rd, rsp);
		check(rd, 32'h20, "auth done flags");
		host.busAccess(1'b0, 8'hF0, 32'h0, rd, rsp);
		check(rsp, 2'b10, "hole response");
		check(rd, 32'h0, "hole data");
		$display("test registers done");
		// Mid-run reset restores defaults and unlocks the data zone
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		host.busAccess(1'b0, 8'h64, 32'h0, rd, rsp);
		check(rd, 32'h001C001C, "policy reset value");
		host.busAccess(1'b0, CTRL_OFS, 32'h0, rd, rsp);
		check(rd, 32'h0, "control reset value");
		doCmd(cr(CMD_WRITE, 4'h0, 3'h0, ERR_NONE));
		$display("test reset done");
		summarize();
	end
endmodule // testbench
